// ### logic/ledblk_top.sv
/*
 * LED setup register and three LED drivers with shared blink timing.
 * Assumes sources are active-high internal indications, sync to core_clk,
 * and that the non-volatile store presents its word once after reset.
 */
`timescale 1ns/1ps

// Contract
// R1: LED0 source from selector bits 3:0
// R2: LED1 source from selector bits 11:8
// R3: LED2 source from selector bits 19:16
// R4: Bit 5 picks 200 ms or 83 ms
// R5: Polarity bits invert source, active high
// R6: Software keeps polarity zero for link/activity
// R7: Flash bits blink asserted source, shared rate; LED0 idle display ignores its flash bit
// R8: Bit 4 with selector 0x8 shows idle
// R9: Software writes reserved bits as zero
// R10: Field defaults loaded from non-volatile store
// R11: One shared counter keeps blinks in phase
module ledblk_top
  import ledblk_pkg::*;
#(
  parameter int BLINK_SLOW_CYCLES = BLINK_SLOW_CYC,
  parameter int BLINK_FAST_CYCLES = BLINK_FAST_CYC
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              nrst,
  // Register port
  input  wire ledblk_req_t       reg_req,
  output logic [31:0]            reg_rdata_ff,
  // Non-volatile defaults
  input  wire ledblk_nvm_t       nvm_word,
  // Indication sources, indexed by selector value
  input  wire logic [15:0]       led_sources,
  input  wire logic              lane_elec_idle,
  // LED pins
  output logic [LED_COUNT-1:0]   led_pin_ff
);

  logic [31:0]              setup_ff;
  logic [31:0]              nxt_setup;
  logic                     loaded_ff;
  logic [BLINK_CNT_W-1:0]   blink_cnt_ff;
  logic [BLINK_CNT_W-1:0]   nxt_blink_cnt;
  logic                     phase_ff;
  logic [BLINK_CNT_W-1:0]   blink_limit;
  logic                     blink_wrap;
  logic                     addr_hit;
  logic                     wr_hit;
  logic [31:0]              nxt_rdata;
  logic [LED_COUNT-1:0]     nxt_pin;
  logic [LED_COUNT-1:0]     src_sel;
  logic [LED_COUNT-1:0]     pol;
  logic [LED_COUNT-1:0]     flash;
  logic                     idle_mode;
  logic                     phase_prev_ff;
  logic                     rate_prev_ff;
  logic                     rate_held_ff;
  logic                     nxt_rate_held;
  logic                     phase_moved;
  logic                     rate_same;
  logic [BLINK_CNT_W-1:0]   phase_age_ff;
  logic [BLINK_CNT_W-1:0]   nxt_phase_age;

  // Register decode
  assign addr_hit  = (reg_req.addr == LED_SETUP_OFS);
  assign wr_hit    = reg_req.wr && addr_hit;
  assign nxt_rdata = (reg_req.rd && addr_hit) ? setup_ff : 32'h0000_0000;

  // Store word wins once, over a software write in the same cycle; earlier writes still land
  assign nxt_setup = (!loaded_ff && nvm_word.valid) ? (nvm_word.data & LED_SETUP_WMASK) :  // [R10]
                     wr_hit ? (reg_req.wdata & LED_SETUP_WMASK) : setup_ff;  // [R9]

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      setup_ff     <= LED_SETUP_RST;
      loaded_ff    <= 1'b0;
      reg_rdata_ff <= 32'h0000_0000;
    end else begin
      setup_ff     <= nxt_setup;
      loaded_ff    <= loaded_ff | nvm_word.valid;
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // Shared blink timebase; >= compare survives a rate change mid-count
  assign blink_limit   = setup_ff[RATE_BIT] ? BLINK_FAST_CYCLES[BLINK_CNT_W-1:0]     // [R4]
                                            : BLINK_SLOW_CYCLES[BLINK_CNT_W-1:0];
  assign blink_wrap    = (blink_cnt_ff >= blink_limit - 1'b1);
  assign nxt_blink_cnt = blink_wrap ? '0 : blink_cnt_ff + 1'b1;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      blink_cnt_ff <= '0;
      phase_ff     <= 1'b1;
    end else begin
      blink_cnt_ff <= nxt_blink_cnt;                      // [R11]
      phase_ff     <= blink_wrap ? ~phase_ff : phase_ff;  // [R11]
    end
  end

  // Checker helper: age of the current phase, and whether the rate bit
  // held still across the run; a rate change shortens or stretches a run
  assign phase_moved   = (phase_ff != phase_prev_ff);
  assign rate_same     = (setup_ff[RATE_BIT] == rate_prev_ff);
  assign nxt_phase_age = phase_moved ? BLINK_CNT_W'(1) : phase_age_ff + 1'b1;
  assign nxt_rate_held = phase_moved ? rate_same : (rate_held_ff && rate_same);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      phase_prev_ff <= 1'b1;
      rate_prev_ff  <= LED_SETUP_RST[RATE_BIT];
      phase_age_ff  <= '0;
      rate_held_ff  <= 1'b1;
    end else begin
      phase_prev_ff <= phase_ff;
      rate_prev_ff  <= setup_ff[RATE_BIT];
      phase_age_ff  <= nxt_phase_age;
      rate_held_ff  <= nxt_rate_held;
    end
  end

  assign idle_mode = setup_ff[DISP_MODE_BIT] &&
                     (setup_ff[SEL_LSB +: SEL_W] == SEL_SW_PIN);

  // Per-LED source select, polarity and flash
  for (genvar i = 0; i < LED_COUNT; i++) begin : g_led
    logic [SEL_W-1:0] sel;
    logic             on;
    assign sel        = setup_ff[i*LED_LANE_W+SEL_LSB +: SEL_W];    // [R1] [R2] [R3]
    assign pol[i]     = setup_ff[i*LED_LANE_W+POL_BIT];
    assign flash[i]   = setup_ff[i*LED_LANE_W+FLASH_BIT];
    assign src_sel[i] = (i == 0 && idle_mode) ? lane_elec_idle      // [R8]
                                              : led_sources[sel];
    // Idle display bypasses flashing so the state reads steadily
    assign on         = src_sel[i] && (!flash[i] || (i == 0 && idle_mode) || phase_ff);  // [R7]
    // Polarity zero drives the pin low when lit
    assign nxt_pin[i] = on ^ ~pol[i];                               // [R5] [R6]
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      led_pin_ff <= {LED_COUNT{1'b1}};
    end else begin
      led_pin_ff <= nxt_pin;
    end
  end

  chk_sw_write: assert property (@(posedge core_clk) disable iff (!nrst)  // [R1]
    (wr_hit && loaded_ff) |=> setup_ff == ($past(reg_req.wdata) & LED_SETUP_WMASK))
    else $error("setup register did not take masked write");

  chk_nvm_load: assert property (@(posedge core_clk) disable iff (!nrst)  // [R10]
    (!loaded_ff && nvm_word.valid) |=> setup_ff == ($past(nvm_word.data) & LED_SETUP_WMASK))
    else $error("store defaults not loaded");

  chk_rate_limit: assert property (@(posedge core_clk) disable iff (!nrst)  // [R4]
    setup_ff[RATE_BIT] |-> blink_limit == BLINK_FAST_CYCLES[BLINK_CNT_W-1:0])
    else $error("fast blink rate not selected");

  chk_phase_wrap: assert property (@(posedge core_clk) disable iff (!nrst)  // [R11]
    (phase_ff != $past(phase_ff)) |-> ($past(blink_cnt_ff) >= $past(blink_limit) - 1))
    else $error("blink phase toggled early");

  chk_led1_steady: assert property (@(posedge core_clk) disable iff (!nrst)  // [R2]
    (!flash[1] && !pol[1]) |=> led_pin_ff[1] == !$past(src_sel[1]))
    else $error("steady active-low LED1 wrong");

  chk_pol_high: assert property (@(posedge core_clk) disable iff (!nrst)  // [R5]
    (pol[0] && !flash[0]) |=> led_pin_ff[0] == $past(src_sel[0]))
    else $error("inverted LED0 not active high");

  chk_flash_off: assert property (@(posedge core_clk) disable iff (!nrst)  // [R7]
    (flash[2] && !phase_ff) |=> led_pin_ff[2] == !$past(pol[2]))
    else $error("flashing LED2 lit in off phase");

  chk_idle_show: assert property (@(posedge core_clk) disable iff (!nrst)  // [R8]
    idle_mode |=> led_pin_ff[0] == ($past(lane_elec_idle) ^ !$past(pol[0])))
    else $error("LED0 not showing lane idle");

  chk_read_back: assert property (@(posedge core_clk) disable iff (!nrst)  // [R3]
    (reg_req.rd && addr_hit) |=> reg_rdata_ff == $past(setup_ff))
    else $error("setup readback mismatch");

  chk_src_led0: assert property (@(posedge core_clk) disable iff (!nrst)  // [R1]
    !idle_mode |-> src_sel[0] == led_sources[setup_ff[SEL_LSB +: SEL_W]])
    else $error("LED0 source not from its selector");

  chk_src_led1: assert property (@(posedge core_clk) disable iff (!nrst)  // [R2]
    src_sel[1] == led_sources[setup_ff[LED_LANE_W+SEL_LSB +: SEL_W]])
    else $error("LED1 source not from its selector");

  chk_src_led2: assert property (@(posedge core_clk) disable iff (!nrst)  // [R3]
    src_sel[2] == led_sources[setup_ff[2*LED_LANE_W+SEL_LSB +: SEL_W]])
    else $error("LED2 source not from its selector");

  chk_flash_on: assert property (@(posedge core_clk) disable iff (!nrst)  // [R7]
    (flash[2] && phase_ff) |=> led_pin_ff[2] == ($past(src_sel[2]) ^ !$past(pol[2])))
    else $error("flashing LED2 wrong in on phase");

  chk_led2_low: assert property (@(posedge core_clk) disable iff (!nrst)  // [R5]
    (!pol[2] && !flash[2]) |=> led_pin_ff[2] == !$past(src_sel[2]))
    else $error("steady active-low LED2 wrong");

  chk_reserved_zero: assert property (@(posedge core_clk) disable iff (!nrst)  // [R9]
    (setup_ff & ~LED_SETUP_WMASK) == 32'h0000_0000)
    else $error("reserved setup bits not zero");

  chk_setup_hold: assert property (@(posedge core_clk) disable iff (!nrst)  // [R10]
    (!wr_hit && (loaded_ff || !nvm_word.valid)) |=> $stable(setup_ff))
    else $error("setup changed without write or load");

  chk_rdata_idle: assert property (@(posedge core_clk) disable iff (!nrst)  // [R9]
    !(reg_req.rd && addr_hit) |=> reg_rdata_ff == 32'h0000_0000)
    else $error("read data not zero without a hit read");

  chk_run_length: assert property (@(posedge core_clk) disable iff (!nrst)  // [R4]
    (phase_moved && rate_held_ff) |-> phase_age_ff == $past(blink_limit))
    else $error("blink phase run length wrong");

  chk_cnt_over: assert property (@(posedge core_clk) disable iff (!nrst)  // [R11]
    (blink_cnt_ff >= blink_limit) |=> blink_cnt_ff == '0)
    else $error("blink counter ran past its limit");

  chk_phase_hold: assert property (@(posedge core_clk) disable iff (!nrst)  // [R11]
    !blink_wrap |=> phase_ff == $past(phase_ff))
    else $error("blink phase moved without wrap");

endmodule

// ### shared/ledblk_pkg.sv
/*
 * Constants and carrier types for the LED setup block.
 * Assumes a 25 MHz core clock and a simple internal register port.
 */
package ledblk_pkg;

  // Register map
  localparam logic [15:0] LED_SETUP_OFS   = 16'h0e00;
  localparam logic [31:0] LED_SETUP_WMASK = 32'h00cfcfff;
  localparam logic [31:0] LED_SETUP_RST   = 32'h00078406;

  // Field layout, one byte lane per LED
  localparam int          LED_COUNT      = 3;
  localparam int          LED_LANE_W     = 8;
  localparam int          SEL_LSB        = 0;
  localparam int          SEL_W          = 4;
  localparam int          POL_BIT        = 6;
  localparam int          FLASH_BIT      = 7;
  localparam int          DISP_MODE_BIT  = 4;
  localparam int          RATE_BIT       = 5;
  localparam logic [3:0]  SEL_SW_PIN     = 4'h8;

  // Blink timing
  localparam int          CLK_KHZ        = 25000;
  localparam int          BLINK_SLOW_MS  = 200;
  localparam int          BLINK_FAST_MS  = 83;
  localparam int          BLINK_SLOW_CYC = BLINK_SLOW_MS * CLK_KHZ;
  localparam int          BLINK_FAST_CYC = BLINK_FAST_MS * CLK_KHZ;
  localparam int          BLINK_CNT_W    = 23;

  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [31:0] wdata;
  } ledblk_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } ledblk_nvm_t;

endpackage

// ### testbench/ledblk_leds.sv
/* Board LED model: which LEDs a viewer sees lit.
   Assumes registered pins and the polarity bits the bench programmed. */
`timescale 1ns/1ps
module ledblk_leds (
  // Pins and polarity
  input  wire logic [2:0] pin,
  input  wire logic [2:0] pol,
  // Seen state
  output logic      [2:0] lit
);
  // Polarity 0 lights on a low pin, 1 on a high pin
  assign lit = pin ~^ pol;
endmodule

// ### testbench/tb_top.sv
/* Self-checking bench for the LED setup block.
   Assumes shortened blink counts and the strobe register port. */
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  import ledblk_pkg::*;
  logic        core_clk, nrst, idle;
  ledblk_req_t req;
  ledblk_nvm_t nvm;
  logic [15:0] src;
  logic [31:0] rd, cfg, sd;
  logic [2:0]  pin, lit, p;
  int          fail_count, compares, seed, n;

  ledblk_top #(.BLINK_SLOW_CYCLES(20), .BLINK_FAST_CYCLES(8)) u_dut (
    .core_clk(core_clk), .nrst(nrst), .reg_req(req), .reg_rdata_ff(rd),
    .nvm_word(nvm), .led_sources(src), .lane_elec_idle(idle), .led_pin_ff(pin));
  ledblk_leds u_leds (.pin(pin), .pol({cfg[22], cfg[14], cfg[6]}), .lit(lit));

  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk) req <= '{a, w, !w, d};
    @(posedge core_clk) req <= '0;
    #1;
  endtask

  function automatic logic exp_lit(int i);
    logic [3:0] s;
    s = cfg[8*i+:4];
    return (i == 0 && cfg[4] && s == 4'h8) ? idle : src[s];
  endfunction

  task automatic close_out;
    $display("fail_count=%0d compares=%0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end

  initial begin
    #400000;
    fail_count++;
    close_out;
  end

  initial begin
    seed = 32'hdca0;
    req = '0; nvm = '0; src = '0; idle = 0; nrst = 0; cfg = LED_SETUP_RST;
    repeat (4) @(posedge core_clk);
    nrst <= 1;
    acc(0, LED_SETUP_OFS, '0);
    `CHK(rd, LED_SETUP_RST)
    `CHK(pin, 3'b111)
    sd = $random(seed);
    @(posedge core_clk) nvm <= '{1'b1, sd};
    // Second valid must be ignored: load happens once per reset
    @(posedge core_clk) nvm <= '{1'b1, ~sd};
    @(posedge core_clk) nvm <= '0;
    cfg = sd & LED_SETUP_WMASK;
    acc(0, LED_SETUP_OFS, '0);
    `CHK(rd, cfg)
    @(posedge core_clk);
    #1;
    `CHK(rd, 32'h0)
    acc(1, LED_SETUP_OFS + 16'h0004, '1);
    acc(0, LED_SETUP_OFS + 16'h0004, '0);
    `CHK(rd, 32'h0)
    acc(0, LED_SETUP_OFS, '0);
    `CHK(rd, cfg)
    for (n = 0; n < 40; n++) begin
      cfg = $random(seed) & LED_SETUP_WMASK & 32'h007f7f7f;
      for (int i = 0; i < 3; i++) if (cfg[8*i+:4] == 4'h4) cfg[8*i+6] = 1'b0;
      if (n % 4 == 0) cfg[3:0] = SEL_SW_PIN;
      acc(1, LED_SETUP_OFS, cfg);
      @(posedge core_clk) begin
        src  <= 16'($random(seed));
        idle <= 1'($random(seed));
      end
      repeat (2) @(posedge core_clk);
      #1;
      for (int i = 0; i < 3; i++) `CHK(lit[i], exp_lit(i))
    end
    @(posedge core_clk) src <= 16'h0001;
    for (int r = 0; r < 2; r++) begin
      cfg = 32'h00c0c0c0 | (r << 5);
      acc(1, LED_SETUP_OFS, cfg);
      repeat (2) @(posedge core_clk);
      #1;
      // First run may be partial, so the second one is measured
      for (int k = 0; k < 2; k++) begin
        p = pin;
        n = 0;
        while (pin === p && n < 50) begin
          @(posedge core_clk);
          #1;
          n++;
        end
      end
      `CHK(n, r ? 8 : 20)
      `CHK(pin, {3{pin[0]}})
    end
    // Mid-run reset: defaults return, then the store beats a same-cycle write
    @(posedge core_clk) nrst <= 0;
    repeat (2) @(posedge core_clk);
    nrst <= 1;
    #1;
    `CHK(pin, 3'b111)
    acc(0, LED_SETUP_OFS, '0);
    `CHK(rd, LED_SETUP_RST)
    sd = $random(seed);
    @(posedge core_clk) begin
      req <= '{LED_SETUP_OFS, 1'b1, 1'b0, ~sd};
      nvm <= '{1'b1, sd};
    end
    @(posedge core_clk) begin
      req <= '0;
      nvm <= '0;
    end
    acc(0, LED_SETUP_OFS, '0);
    `CHK(rd, sd & LED_SETUP_WMASK)
    close_out;
  end
endmodule
